// File: include/pin_mux_pkg.sv
package pin_mux_pkg;

  // ----------------------------------------------------------------
  // widths and address space
  // ----------------------------------------------------------------
  localparam int PORT_W      = 8;
  localparam int CTRL_W      = 4;
  localparam int ADDR_W      = 24;
  localparam int BANK_LSB    = 16;
  localparam int BANK_W      = 8;
  localparam int CS_W        = 5;
  localparam logic [BANK_W-1:0] BANK_LIMIT_B = 8'h10;  // first bank unreachable in mode b
  localparam logic [BANK_W-1:0] BANK_ZERO    = 8'h00;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [PORT_W-1:0] DIR_RESET   = 8'h00;  // all pins input
  localparam logic [PORT_W-1:0] LATCH_RESET = 8'h00;

  // fourth port bits with bus active; sixth port subclock bit, serial width, key input lsb
  localparam int HOLD_BIT  = 0;
  localparam int READY_BIT = 1;
  localparam int PHASE_BIT = 2;
  localparam int SUBCLK_BIT = 7;
  localparam int SERIAL_W  = 4;
  localparam int KEY_LSB   = 4;

  typedef enum logic [1:0] {
    SINGLE_CHIP,
    MEM_EXPANSION,
    MICROPROCESSOR
  } proc_mode_type;

  // straps seen by the mux
  typedef struct packed {
    logic processor_mode_input;
    logic expansion_request;
    logic byte_width_select;
    logic bus_method_select;
  } strap_type;

  // one external bus cycle as the core presents it
  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic [15:0]       wdata;
    logic              data_phase;
    logic              write;
    logic              byte_high_enable;
    logic              ale;
    logic              hold_acknowledge;
    logic              read_strobe;
    logic              write_low_byte;
    logic              write_high_byte;
    logic              resample_out;
    logic              internal_enable;
  } bus_req_type;

  // per-port pin pair
  typedef struct packed {
    logic [PORT_W-1:0] out;
    logic [PORT_W-1:0] oe;
  } pin_drive_type;

  // block state
  typedef struct packed {
    proc_mode_type      mode;
    logic               wide16;
    logic               mode_a;
    logic               latched;
    logic [PORT_W-1:0]  dir0;
    logic [PORT_W-1:0]  dir1;
    logic [PORT_W-1:0]  dir2;
    logic [PORT_W-1:0]  dir3;
    logic [PORT_W-1:0]  dir4;
    logic [PORT_W-1:0]  dir6;
    logic [PORT_W-1:0]  dir10;
    logic [PORT_W-1:0]  out_only_latch;
    logic               out_only_drive;
    pin_drive_type      p0;
    pin_drive_type      p1;
    pin_drive_type      p2;
    pin_drive_type      p3;
    pin_drive_type      p4;
    logic               enable_pin;
    logic               bank_fault;
  } state_type;

endpackage

// File: rtl/external_bus_pin_function_mux.sv
// Behaviour
// - processor-mode low gives single-chip or expansion; high gives microprocessor operation
// - reset input high puts the device in its reset state
// - with bus active, width select low means 16-bit data, high means 8-bit
// - with bus active, method select high is bus mode a, low is mode b
// - single-chip ports are per-pin directed, all inputs after reset
// - first port gives a0-a7 in mode a; chip selects, resample, a16-a17 in b
// - second port: 16-bit carries d8-d15 or a8-a15; 8-bit gives only a8-a15
// - third port multiplexes d0-d7 with a16-a23 in mode a, a0-a7 in b
// - control port gives r/w, bhe, ale, hold_acknowledge in a; wel, weh, ale, hold_acknowledge in b
// - fourth port bits 0,1,2 become hold in, ready in, phase clock out
// - in expansion only, phase clock pin may return to plain port use
// - enable pin shows internal access; in mode b with bus it is read strobe
// - output-only port floats until its latch is written; low nibble serves serial
// - sixth port bit 7 can output subclock; pins feed interrupts and b timers
// - upper four bits of the last port also act as key interrupt inputs
// - 16 mbyte space is 256 banks of 64 kbyte selected by top address byte
// - in bus mode b banks 10h to ffh are inaccessible
// - internal rom, ram and peripheral registers all live in bank zero
module external_bus_pin_function_mux (
  input  wire logic                               ref_clk_in,
  input  wire logic                               reset_in,
  input  wire pin_mux_pkg::strap_type             strap_in,
  input  wire pin_mux_pkg::bus_req_type           bus_req_in,
  input  wire logic                               phase_clock_in,
  input  wire logic                               subclock_in,
  input  wire logic                               phase_pin_as_port_in,
  input  wire logic                               subclock_select_in,
  input  wire logic [pin_mux_pkg::PORT_W-1:0]     port_latch_in,
  input  wire logic [pin_mux_pkg::PORT_W-1:0]     dir_wdata_in,
  input  wire logic [6:0]                         dir_we_in,
  input  wire logic                               out_only_we_in,
  input  wire logic [pin_mux_pkg::PORT_W-1:0]     out_only_wdata_in,
  input  wire logic [pin_mux_pkg::SERIAL_W-1:0]   serial_tx_in,
  input  wire logic                               serial_en_in,
  input  wire logic [pin_mux_pkg::PORT_W-1:0]     p0_pin_in,
  input  wire logic [pin_mux_pkg::PORT_W-1:0]     p1_pin_in,
  input  wire logic [pin_mux_pkg::PORT_W-1:0]     p2_pin_in,
  input  wire logic [pin_mux_pkg::CTRL_W-1:0]     p3_pin_in,
  input  wire logic [pin_mux_pkg::PORT_W-1:0]     p4_pin_in,
  input  wire logic [pin_mux_pkg::PORT_W-1:0]     p6_pin_in,
  input  wire logic [pin_mux_pkg::PORT_W-1:0]     p10_pin_in,
  output logic      [pin_mux_pkg::PORT_W-1:0]     address_low_port_out,
  output logic      [pin_mux_pkg::PORT_W-1:0]     address_low_port_oe_out,
  output logic      [pin_mux_pkg::PORT_W-1:0]     data_high_port_out,
  output logic      [pin_mux_pkg::PORT_W-1:0]     data_high_port_oe_out,
  output logic      [pin_mux_pkg::PORT_W-1:0]     data_low_port_out,
  output logic      [pin_mux_pkg::PORT_W-1:0]     data_low_port_oe_out,
  output logic      [pin_mux_pkg::CTRL_W-1:0]     bus_control_port_out,
  output logic      [pin_mux_pkg::CTRL_W-1:0]     bus_control_port_oe_out,
  output logic      [pin_mux_pkg::PORT_W-1:0]     p4_out,
  output logic      [pin_mux_pkg::PORT_W-1:0]     p4_oe_out,
  output logic      [pin_mux_pkg::PORT_W-1:0]     output_only_port_out,
  output logic      [pin_mux_pkg::PORT_W-1:0]     output_only_port_oe_out,
  output logic                                    subclock_pin_out,
  output logic                                    subclock_pin_oe_out,
  output logic      [pin_mux_pkg::PORT_W-1:0]     p6_oe_out,
  output logic      [pin_mux_pkg::PORT_W-1:0]     p10_oe_out,
  output logic      [pin_mux_pkg::CS_W-1:0]       chip_selects_out,
  output logic      [2:0]                         external_interrupt_inputs_out,
  output logic      [2:0]                         timer_b_inputs_out,
  output logic      [3:0]                         key_inputs_out,
  output logic                                    hold_request_out,
  output logic                                    ready_out,
  output logic                                    enable_pin_out,
  output logic      [pin_mux_pkg::PORT_W-1:0]     data_in_out,
  output logic                                    bus_active_out,
  output logic                                    mode_a_out,
  output logic                                    wide16_out,
  output logic                                    bank_fault_out,
  output logic                                    internal_bank_out
);
  import pin_mux_pkg::*;

  // ----------------------------------------------------------------
  // pin input synchronisers (two flops, first read only by second)
  // ----------------------------------------------------------------
  logic [PORT_W-1:0] p1_s1, p1_s2, p2_s1, p2_s2, p4_s1, p4_s2;
  logic [PORT_W-1:0] p6_s1, p6_s2, p10_s1, p10_s2;
  strap_type         strap_s1, strap_s2;
  // straps are pins too; reset is held long enough to cover the sync delay
  always_ff @(posedge ref_clk_in) begin
    strap_s1 <= strap_in;
    strap_s2 <= strap_s1;
    p1_s1  <= p1_pin_in;
    p1_s2  <= p1_s1;
    p2_s1  <= p2_pin_in;
    p2_s2  <= p2_s1;
    p4_s1  <= p4_pin_in;
    p4_s2  <= p4_s1;
    p6_s1  <= p6_pin_in;
    p6_s2  <= p6_s1;
    p10_s1 <= p10_pin_in;
    p10_s2 <= p10_s1;
  end

  // address bank extraction, used by several decoders
  function automatic logic [BANK_W-1:0] bank_of(input logic [ADDR_W-1:0] a);
    return a[BANK_LSB +: BANK_W];
  endfunction

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  state_type st_ff, nxt_st;
  logic      bus_active;

  assign bus_active = (st_ff.mode != SINGLE_CHIP);

  always_comb begin
    logic [BANK_W-1:0] bank;
    logic              fault;
    bank  = bank_of(bus_req_in.address);
    fault = 1'b0;
    nxt_st = st_ff;
    // straps sampled only while reset is held; static afterwards
    if (reset_in) begin
      nxt_st.mode    = strap_s2.processor_mode_input ? MICROPROCESSOR :
                       (strap_s2.expansion_request ? MEM_EXPANSION : SINGLE_CHIP);
      nxt_st.wide16  = ~strap_s2.byte_width_select;
      nxt_st.mode_a  = strap_s2.bus_method_select;
      nxt_st.latched = 1'b1;
    end
    // direction registers of the first four ports only meaningful in single-chip port use
    if (dir_we_in[0]) nxt_st.dir0  = dir_wdata_in;
    if (dir_we_in[1]) nxt_st.dir1  = dir_wdata_in;
    if (dir_we_in[2]) nxt_st.dir2  = dir_wdata_in;
    if (dir_we_in[3]) nxt_st.dir3  = dir_wdata_in;
    if (dir_we_in[4]) nxt_st.dir4  = dir_wdata_in;
    if (dir_we_in[5]) nxt_st.dir6  = dir_wdata_in;
    if (dir_we_in[6]) nxt_st.dir10 = dir_wdata_in;
    // output-only port starts driving on first latch write
    if (out_only_we_in) begin
      nxt_st.out_only_latch = out_only_wdata_in;
      nxt_st.out_only_drive = 1'b1;
    end
    // default port behaviour: latch value under direction control
    nxt_st.p0 = '{out: port_latch_in, oe: st_ff.dir0};
    nxt_st.p1 = '{out: port_latch_in, oe: st_ff.dir1};
    nxt_st.p2 = '{out: port_latch_in, oe: st_ff.dir2};
    nxt_st.p3 = '{out: port_latch_in, oe: st_ff.dir3 & 8'h0F};
    nxt_st.p4 = '{out: port_latch_in, oe: st_ff.dir4};
    if (bus_active) begin
      // first port
      if (st_ff.mode_a)
        nxt_st.p0.out = bus_req_in.address[7:0];
      else begin
        nxt_st.p0.out = {bus_req_in.address[17:16], bus_req_in.resample_out,
                         chip_selects_out};
      end
      nxt_st.p0.oe = 8'hFF;
      // second port
      if (st_ff.wide16 && bus_req_in.data_phase) begin
        nxt_st.p1.out = bus_req_in.wdata[15:8];
        nxt_st.p1.oe  = {PORT_W{bus_req_in.write}};
      end else begin
        nxt_st.p1.out = bus_req_in.address[15:8];
        nxt_st.p1.oe  = 8'hFF;
      end
      // third port time-shared data and address
      if (bus_req_in.data_phase) begin
        nxt_st.p2.out = bus_req_in.wdata[7:0];
        nxt_st.p2.oe  = {PORT_W{bus_req_in.write}};
      end else begin
        nxt_st.p2.out = st_ff.mode_a ? bus_req_in.address[23:16]
                                     : bus_req_in.address[7:0];
        nxt_st.p2.oe  = 8'hFF;
      end
      // control port
      if (st_ff.mode_a)
        nxt_st.p3.out = {4'h0, bus_req_in.hold_acknowledge, bus_req_in.ale,
                         bus_req_in.byte_high_enable, bus_req_in.write};
      else
        nxt_st.p3.out = {4'h0, bus_req_in.hold_acknowledge, bus_req_in.ale,
                         bus_req_in.write_high_byte, bus_req_in.write_low_byte};
      nxt_st.p3.oe = 8'h0F;
      // fourth port: hold, ready inputs and phase clock
      nxt_st.p4.oe[HOLD_BIT]  = 1'b0;
      nxt_st.p4.oe[READY_BIT] = 1'b0;
      if (!(st_ff.mode == MEM_EXPANSION && phase_pin_as_port_in)) begin
        nxt_st.p4.out[PHASE_BIT] = phase_clock_in;
        nxt_st.p4.oe[PHASE_BIT]  = 1'b1;
      end
      // mode b reaches only the first sixteen banks
      fault = !st_ff.mode_a && (bank >= BANK_LIMIT_B);
    end
    nxt_st.bank_fault = fault;
    nxt_st.enable_pin = (bus_active && !st_ff.mode_a) ? bus_req_in.read_strobe
                                                      : bus_req_in.internal_enable;
    if (reset_in) begin
      nxt_st.dir0 = DIR_RESET;
      nxt_st.dir1 = DIR_RESET;
      nxt_st.dir2 = DIR_RESET;
      nxt_st.dir3 = DIR_RESET;
      nxt_st.dir4 = DIR_RESET;
      nxt_st.dir6 = DIR_RESET;
      nxt_st.dir10 = DIR_RESET;
      nxt_st.out_only_latch = LATCH_RESET;
      nxt_st.out_only_drive = 1'b0;
      nxt_st.p0 = '0;
      nxt_st.p1 = '0;
      nxt_st.p2 = '0;
      nxt_st.p3 = '0;
      nxt_st.p4 = '0;
      nxt_st.enable_pin = 1'b0;
      nxt_st.bank_fault = 1'b0;
    end
  end

  // single register for the whole state
  always_ff @(posedge ref_clk_in) begin
    st_ff <= nxt_st;
  end

  // ----------------------------------------------------------------
  // combinational decodes and pin outputs
  // ----------------------------------------------------------------
  // chip selects in mode b: one per 64 kbyte bank for banks 0 to 4 only, active low; bank 0 is cs0
  always_comb begin
    logic [BANK_W-1:0] cs_bank;
    cs_bank          = bank_of(bus_req_in.address);
    chip_selects_out = {CS_W{1'b1}};
    if (bus_active && !st_ff.mode_a && bus_req_in.ale == 1'b0 &&
        cs_bank < BANK_LIMIT_B && cs_bank < BANK_W'(CS_W))
      chip_selects_out[cs_bank[2:0]] = 1'b0;
  end

  assign address_low_port_out    = st_ff.p0.out;
  assign address_low_port_oe_out = st_ff.p0.oe;
  assign data_high_port_out      = st_ff.p1.out;
  assign data_high_port_oe_out   = st_ff.p1.oe;
  assign data_low_port_out       = st_ff.p2.out;
  assign data_low_port_oe_out    = st_ff.p2.oe;
  assign bus_control_port_out    = st_ff.p3.out[CTRL_W-1:0];
  assign bus_control_port_oe_out = st_ff.p3.oe[CTRL_W-1:0];
  assign p4_out                  = st_ff.p4.out;
  assign p4_oe_out               = st_ff.p4.oe;
  // serial channel borrows the low nibble when enabled
  assign output_only_port_out    = serial_en_in ?
      {st_ff.out_only_latch[PORT_W-1:SERIAL_W], serial_tx_in} : st_ff.out_only_latch;
  assign output_only_port_oe_out = {PORT_W{st_ff.out_only_drive}};
  assign subclock_pin_out        = subclock_select_in & subclock_in;
  assign subclock_pin_oe_out     = subclock_select_in | st_ff.dir6[SUBCLK_BIT];
  assign p6_oe_out               = st_ff.dir6;
  assign p10_oe_out              = st_ff.dir10;
  // alternate inputs of the sixth and last ports
  assign external_interrupt_inputs_out = p6_s2[5:3];
  assign timer_b_inputs_out            = {p6_s2[6], p6_s2[1:0]};
  assign key_inputs_out                = p10_s2[KEY_LSB +: 4];
  assign hold_request_out = bus_active & p4_s2[HOLD_BIT];
  assign ready_out        = ~bus_active | p4_s2[READY_BIT];
  assign enable_pin_out   = st_ff.enable_pin;
  assign data_in_out      = p2_s2;
  assign bus_active_out   = bus_active;
  assign mode_a_out       = st_ff.mode_a;
  assign wide16_out       = st_ff.wide16;
  assign bank_fault_out   = st_ff.bank_fault;
  // on-chip memory and registers decode only in bank zero
  assign internal_bank_out = (bank_of(bus_req_in.address) == BANK_ZERO);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_dir_reset_input: assert property (@(posedge ref_clk_in)
    reset_in |=> (st_ff.dir0 == DIR_RESET && address_low_port_oe_out == 8'h00))
    else $error("direction not cleared by reset");
  a_out_only_float: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (!out_only_we_in && !st_ff.out_only_drive) |=> output_only_port_oe_out == 8'h00)
    else $error("output-only port drove before latch write");
  a_out_only_drive: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    out_only_we_in |=> output_only_port_oe_out == 8'hFF)
    else $error("output-only port not driving after write");
  a_mode_static: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    $stable(st_ff.mode) && $stable(st_ff.mode_a) && $stable(st_ff.wide16))
    else $error("mode changed outside reset");
  a_mode_b_bank: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (bus_active && !st_ff.mode_a && bus_req_in.address[23:20] != 4'h0)
      |=> bank_fault_out)
    else $error("mode b bank above limit not flagged");
  a_enable_strobe: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (bus_active && !st_ff.mode_a) |=> enable_pin_out == $past(bus_req_in.read_strobe))
    else $error("enable pin not read strobe in mode b");
  a_port0_addr_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (bus_active && st_ff.mode_a) |=> address_low_port_out == $past(bus_req_in.address[7:0]))
    else $error("first port not low address in mode a");
  a_port2_addr_b: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (bus_active && !st_ff.mode_a && !bus_req_in.data_phase)
      |=> data_low_port_out == $past(bus_req_in.address[7:0]))
    else $error("third port not a0-a7 in mode b");
  a_port1_narrow: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (bus_active && !st_ff.wide16) |=> data_high_port_out == $past(bus_req_in.address[15:8]))
    else $error("second port not address in 8-bit mode");
  a_hold_ready_in: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    bus_active |=> (p4_oe_out[1:0] == 2'b00))
    else $error("hold or ready pin driven");
  a_cs_idle_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (bus_active && st_ff.mode_a) |-> chip_selects_out == {CS_W{1'b1}})
    else $error("chip select active in mode a");
  a_ctrl_port_oe: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    bus_active |=> bus_control_port_oe_out == 4'hF)
    else $error("control port not driven with bus active");

endmodule

// File: testbench/ext_mem_model.sv
// ----------------------------------------------------------------
// external memory on the low data lanes
// ----------------------------------------------------------------
module ext_mem_model (
  input  wire logic       ref_clk_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] data_oe_in,
  output logic      [7:0] data_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] last_ff;
  // remember what was last on the lanes
  always_ff @(posedge ref_clk_in) begin
    last_ff <= data_out;
  end
  // answer when the device lets go; a toggling value stops stale data from passing
  always_comb begin
    if (data_oe_in == 8'h00) begin
      data_out = addr_in ^ 8'h5a;
    end else begin
      data_out = ~last_ff;
    end
  end
endmodule

// File: testbench/external_bus_pin_function_mux_tb.sv
// ----------------------------------------------------------------
// bench for the pin function mux
// ----------------------------------------------------------------
module external_bus_pin_function_mux_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pin_mux_pkg::*;
  logic        ref_clk_in, reset_in, phase_clock_in, subclock_in, phase_pin_as_port_in;
  logic        subclock_select_in, out_only_we_in, serial_en_in;
  strap_type   strap_in;
  bus_req_type bus_req_in;
  logic [7:0]  port_latch_in, dir_wdata_in, out_only_wdata_in, p0_pin_in, p1_pin_in, p2_pin_in;
  logic [6:0]  dir_we_in;
  logic [3:0]  serial_tx_in, p3_pin_in, bus_control_port_out, bus_control_port_oe_out;
  logic [7:0]  p4_pin_in, p6_pin_in, p10_pin_in, address_low_port_out, address_low_port_oe_out;
  logic [7:0]  data_high_port_out, data_high_port_oe_out, data_low_port_out, data_low_port_oe_out;
  logic [7:0]  p4_out, p4_oe_out, output_only_port_out, output_only_port_oe_out;
  logic [7:0]  p6_oe_out, p10_oe_out, data_in_out;
  logic [4:0]  chip_selects_out;
  logic [2:0]  external_interrupt_inputs_out, timer_b_inputs_out;
  logic [3:0]  key_inputs_out;
  logic        subclock_pin_out, subclock_pin_oe_out, hold_request_out, ready_out;
  logic        enable_pin_out, bus_active_out, mode_a_out, wide16_out;
  logic        bank_fault_out, internal_bank_out;
  int          mismatches, compares;

  external_bus_pin_function_mux i_external_bus_pin_function_mux (
    .ref_clk_in, .reset_in, .strap_in, .bus_req_in, .phase_clock_in, .subclock_in,
    .phase_pin_as_port_in, .subclock_select_in, .port_latch_in, .dir_wdata_in, .dir_we_in,
    .out_only_we_in, .out_only_wdata_in, .serial_tx_in, .serial_en_in, .p0_pin_in,
    .p1_pin_in, .p2_pin_in, .p3_pin_in, .p4_pin_in, .p6_pin_in, .p10_pin_in,
    .address_low_port_out, .address_low_port_oe_out, .data_high_port_out,
    .data_high_port_oe_out, .data_low_port_out, .data_low_port_oe_out,
    .bus_control_port_out, .bus_control_port_oe_out, .p4_out, .p4_oe_out,
    .output_only_port_out, .output_only_port_oe_out, .subclock_pin_out,
    .subclock_pin_oe_out, .p6_oe_out, .p10_oe_out, .chip_selects_out,
    .external_interrupt_inputs_out, .timer_b_inputs_out, .key_inputs_out,
    .hold_request_out, .ready_out, .enable_pin_out, .data_in_out, .bus_active_out,
    .mode_a_out, .wide16_out, .bank_fault_out, .internal_bank_out);

  // memory answers on the low data lanes using the low address byte
  ext_mem_model i_ext_mem_model (
    .ref_clk_in (ref_clk_in),
    .addr_in    (address_low_port_out),
    .data_oe_in (data_low_port_oe_out),
    .data_out   (p2_pin_in));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end

  task automatic step(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // straps only count while reset is held, so every mode change goes through reset
  task automatic restart(input logic [3:0] s);
    strap_in = strap_type'(s);
    reset_in = 1'b1;
    step(16);
    reset_in = 1'b0;
    step(1);
  endtask

  task automatic dir_write(input int port, input logic [7:0] v);
    dir_wdata_in = v;
    dir_we_in = 7'h01 << port;
    step(1);
    dir_we_in = 7'h00;
    step(2);
  endtask

  task automatic cycle(input logic [23:0] a, input logic ph, input logic wr);
    bus_req_in.address = a;
    bus_req_in.data_phase = ph;
    bus_req_in.write = wr;
    step(4);
  endtask

  task automatic results();
    if (mismatches == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // a hang costs a mismatch and ends the run the normal way
  initial begin
    #50000;
    mismatches++;
    results();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    mismatches = 0; compares = 0; reset_in = 1'b1; strap_in = '0; bus_req_in = '0;
    phase_clock_in = 1'b0; subclock_in = 1'b0; phase_pin_as_port_in = 1'b0;
    subclock_select_in = 1'b0; out_only_we_in = 1'b0; serial_en_in = 1'b0;
    port_latch_in = 8'h00; dir_wdata_in = 8'h00; dir_we_in = 7'h00; serial_tx_in = 4'h0;
    out_only_wdata_in = 8'h00; p0_pin_in = 8'h00; p1_pin_in = 8'h00; p3_pin_in = 4'h0;
    p4_pin_in = 8'h00; p6_pin_in = 8'h00; p10_pin_in = 8'h00;
    // single chip: everything floats after reset, then per-pin direction
    restart(4'b0000);
    check("bus_active", bus_active_out, 0);
    check("p0_oe", address_low_port_oe_out, 0);
    check("p2_oe", data_low_port_oe_out, 0);
    check("p9_oe", output_only_port_oe_out, 0);
    check("p10_oe", p10_oe_out, 0);
    dir_write(0, 8'ha5);
    check("p0_oe", address_low_port_oe_out, 8'ha5);
    out_only_wdata_in = 8'h3c; serial_tx_in = 4'h9; out_only_we_in = 1'b1;
    step(1);
    out_only_we_in = 1'b0;
    step(2);
    check("p9_oe", output_only_port_oe_out, 8'hff);
    check("p9_out", output_only_port_out, 8'h3c);
    serial_en_in = 1'b1;
    step(1);
    check("p9_serial", output_only_port_out, 8'h39);
    p6_pin_in = 8'h28; p10_pin_in = 8'ha0; subclock_select_in = 1'b1;
    subclock_in = 1'b1;
    step(3);
    check("int_in", external_interrupt_inputs_out, 3'h5);
    check("key_in", key_inputs_out, 4'ha);
    check("sub_oe", subclock_pin_oe_out, 1);
    check("sub_out", subclock_pin_out, 1);
    check("timer_b_in", timer_b_inputs_out, 0);
    // microprocessor, 16-bit, mode a
    restart(4'b1001);
    check("mode_a", mode_a_out, 1);
    check("wide16", wide16_out, 1);
    check("bus_active", bus_active_out, 1);
    strap_in = strap_type'(4'b1010);
    step(2);
    check("mode_held", mode_a_out, 1);
    cycle(24'h12_3456, 1'b0, 1'b0);
    check("p0_addr", address_low_port_out, 8'h56);
    check("p1_addr", data_high_port_out, 8'h34);
    check("p2_addr", data_low_port_out, 8'h12);
    check("bank0", internal_bank_out, 0);
    check("fault_a", bank_fault_out, 0);
    bus_req_in.wdata = 16'hbeef;
    cycle(24'h12_3456, 1'b1, 1'b1);
    check("p1_data", data_high_port_out, 8'hbe);
    check("p2_data", data_low_port_out, 8'hef);
    check("p2_oe", data_low_port_oe_out, 8'hff);
    check("p1_oe", data_high_port_oe_out, 8'hff);
    check("ctrl_a", bus_control_port_out, 4'h1);
    check("ctrl_oe", bus_control_port_oe_out, 4'hf);
    cycle(24'h12_3456, 1'b1, 1'b0);
    check("read_data", data_in_out, 8'h0c);
    phase_pin_as_port_in = 1'b1;
    cycle(24'h00_8000, 1'b0, 1'b0);
    check("bank0", internal_bank_out, 1);
    check("phase_oe", p4_oe_out[PHASE_BIT], 1);
    check("phase_micro", p4_oe_out[PHASE_BIT], 1);
    p4_pin_in = 8'h01;
    step(3);
    check("hold", hold_request_out, 1);
    check("ready", ready_out, 0);
    // expansion, 8-bit, mode b
    restart(4'b0110);
    check("bus_active", bus_active_out, 1);
    check("mode_b", mode_a_out, 0);
    check("wide8", wide16_out, 0);
    phase_pin_as_port_in = 1'b0;
    bus_req_in.write_high_byte = 1'b1;
    bus_req_in.read_strobe = 1'b1;
    cycle(24'h0f_3456, 1'b0, 1'b0);
    check("p2_addr_b", data_low_port_out, 8'h56);
    check("p1_addr_b", data_high_port_out, 8'h34);
    check("a17_a16", address_low_port_out[7:6], 2'b11);
    check("fault_b", bank_fault_out, 0);
    check("read_strobe", enable_pin_out, 1);
    check("ctrl_b", bus_control_port_out, 4'h2);
    check("phase_exp", p4_oe_out[PHASE_BIT], 1);
    bus_req_in.read_strobe = 1'b0;
    cycle(24'h10_0000, 1'b0, 1'b0);
    check("fault_b", bank_fault_out, 1);
    check("read_strobe", enable_pin_out, 0);
    cycle(24'h02_0000, 1'b0, 1'b0);
    check("cs_bank2", chip_selects_out, 5'h1b);
    check("p0_cs", address_low_port_out[4:0], 5'h1b);
    phase_pin_as_port_in = 1'b1;
    dir_write(4, 8'h00);
    check("phase_port", p4_oe_out[PHASE_BIT], 0);
    results();
  end
endmodule
